/* hw/acp_config_port.sv */
// Serial configuration port with strap fallback and shadowed setup registers
`timescale 1ns/1ps
module acp_config_port
	import acp_pkg::*;
#(
	parameter logic [7:0] CHIP_ID    = 8'hA5, // Arbitrary identification value
	parameter logic [7:0] CHIP_GRADE = 8'h00  // Arbitrary grade value
) (
	// Clock and reset
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST,
	// Serial port pins
	input  wire logic        I_SERIAL_CLOCK_FORMAT_STRAP,
	input  wire logic        I_SELECT_N,
	input  wire logic        I_SERIAL_DATA_STABILIZER_STRAP,
	output logic             O_SERIAL_DATA_STABILIZER_STRAP,
	output logic             O_SERIAL_DATA_STABILIZER_STRAP_OE,
	// Static control pins
	input  wire logic        I_OUTPUT_ENABLE_N,
	input  wire logic        I_POWER_DOWN_PIN,
	// Converter controls
	output logic             O_STRAP_MODE,
	output logic             O_POWER_DOWN,
	output logic             O_STANDBY,
	output logic             O_DUTY_CYCLE_STABILIZER,
	output logic [1:0]       O_DATA_FORMAT_SELECT,
	output logic [1:0]       O_OUTPUT_HIZ,
	output logic [1:0]       O_DATA_CLOCK_OUT_INVERT,
	output logic [15:0]      O_DATA_CLOCK_OUT_DELAY,
	output logic [15:0]      O_TEST_MODE,
	output logic [15:0]      O_OFFSET_ADJUST,
	output logic [7:0]       O_VREF_SELECT
);
	import acp_pkg::*;

	typedef logic [1:0][SHADOW_N-1:0][7:0] acp_bank_type;

	typedef struct packed {
		logic          decided;
		logic [1:0]    wait_cnt;
		logic          strap;
		acp_phase_type phase;
		logic [3:0]    icnt;
		logic [2:0]    bcnt;
		logic [15:0]   instr;
		logic [7:0]    rx;
		logic [7:0]    tx;
		logic          rd;
		logic [1:0]    left;
		logic [12:0]   addr;
		logic          lsb_first;
		logic [1:0]    chan;
		logic          xfer;
		acp_bank_type  shadow;
		acp_bank_type  active;
		logic          sdio_o;
		logic          sdio_oe;
		logic          pd;
		logic          sb;
		logic          duty_cycle_stabilizer;
		logic [1:0]    fmt;
		logic [1:0]    hiz;
		logic [1:0]    inv;
	} acp_state_type;

	acp_state_type s_q;
	acp_state_type s_d;
	acp_bank_type  bank_rst;

	acp_pins_if pins ();

	// Pin synchronisers
	acp_pin_sync u_sync (
		.i_clk  (I_CORE_CLK),
		.i_rst  (I_RST),
		.i_pins ({I_POWER_DOWN_PIN, I_OUTPUT_ENABLE_N, I_SERIAL_DATA_STABILIZER_STRAP,
			I_SELECT_N, I_SERIAL_CLOCK_FORMAT_STRAP}),
		.pins   (pins.src)
	);

	// Reset image of both register banks
	for (genvar c = 0; c < 2; c++) begin : g_bank
		for (genvar r = 0; r < SHADOW_N; r++) begin : g_reg
			assign bank_rst[c][r] = acp_shadow_rst(5'(r));
		end
	end

	function automatic logic in_shadow(input logic [12:0] a);
		return (a >= ADDR_SHADOW_LO) && (a <= ADDR_SHADOW_HI);
	endfunction

	function automatic logic [4:0] shadow_idx(input logic [12:0] a);
		return 5'(a - ADDR_SHADOW_LO);
	endfunction

	// Global setup registers ignore the channel index
	function automatic logic is_global(input logic [12:0] a);
		return (a == ADDR_POWER_MODE) || (a == ADDR_CLOCK) || (a == ADDR_VREF);
	endfunction

	// Readback value at one address
	function automatic logic [7:0] read_byte(input acp_state_type st, input logic [12:0] a);
		logic [7:0] v;
		v = ZERO_BYTE;
		if (a == ADDR_PORT_CFG)
			v[LSB_FIRST_BIT] = st.lsb_first;
		else if (a == ADDR_CHIP_ID)
			v = CHIP_ID;
		else if (a == ADDR_CHIP_GRADE)
			v = CHIP_GRADE;
		else if (a == ADDR_CHAN_IDX)
			v[1:0] = st.chan;
		else if (a == ADDR_TRANSFER)
			v[TRANSFER_BIT] = st.xfer;
		else if (in_shadow(a))
			v = st.shadow[st.chan[0] ? 0 : 1][shadow_idx(a)];
		return v;
	endfunction

	// Next-state logic of the whole port
	always_comb begin
		logic       d;
		logic [7:0] nb;
		logic [15:0] ni;
		logic [4:0] ix;
		d  = pins.sdio;
		nb = s_q.lsb_first ? {d, s_q.rx[7:1]} : {s_q.rx[6:0], d};
		ni = {s_q.instr[14:0], d};
		ix = shadow_idx(s_q.addr);
		s_d = s_q;
		// Transfer copies the shadow bank and then clears itself
		if (s_q.xfer) begin
			s_d.active = s_q.shadow;
			s_d.xfer   = 1'b0;
		end
		if (!s_q.decided) begin
			// Let the synchronisers settle, then latch the select level once
			if (s_q.wait_cnt == STRAP_WAIT) begin
				s_d.decided = 1'b1;
				s_d.strap   = pins.sel_n;
			end else begin
				s_d.wait_cnt = s_q.wait_cnt + 2'h1;
			end
		end else if (s_q.strap) begin
			s_d.sdio_oe = 1'b0;
			s_d.phase   = ACP_IDLE;
		end else if (pins.sel_n) begin
			s_d.sdio_oe = 1'b0;
			// A rise mid-byte, after the last byte, or while streaming ends the frame
			if (pins.sel_rise && ((s_q.phase == ACP_INSTR && (s_q.icnt & INSTR_BYTE_MASK) != 4'h0)
					|| (s_q.phase == ACP_DATA && (s_q.bcnt != 3'h0 || s_q.left == LEN_STREAM))
					|| s_q.phase == ACP_DONE)) begin
				s_d.phase = ACP_IDLE;
			end
		end else if (pins.sclk_rise) begin
			case (s_q.phase)
				ACP_IDLE: begin
					s_d.instr = {15'h0000, d};
					s_d.icnt  = 4'h1;
					s_d.phase = ACP_INSTR;
				end
				ACP_INSTR: begin
					s_d.instr = ni;
					s_d.icnt  = s_q.icnt + 4'h1;
					if (s_q.icnt == INSTR_LAST) begin
						s_d.phase = ACP_DATA;
						s_d.rd    = ni[INSTR_RW_POS];
						s_d.left  = ni[INSTR_LEN_HI:INSTR_LEN_LO];
						s_d.addr  = ni[ADDR_W-1:0];
						s_d.bcnt  = 3'h0;
						s_d.tx    = read_byte(s_q, ni[ADDR_W-1:0]);
					end
				end
				ACP_DATA: begin
					s_d.rx   = nb;
					s_d.bcnt = s_q.bcnt + 3'h1;
					if (s_q.bcnt == BIT_LAST) begin
						if (!s_q.rd) begin
							if (s_q.addr == ADDR_PORT_CFG)
								s_d.lsb_first = nb[LSB_FIRST_BIT];
							else if (s_q.addr == ADDR_CHAN_IDX)
								s_d.chan = nb[1:0];
							else if (s_q.addr == ADDR_TRANSFER && nb[TRANSFER_BIT])
								s_d.xfer = 1'b1;
							else if (in_shadow(s_q.addr)) begin
								for (int c = 0; c < 2; c++) begin
									if (is_global(s_q.addr) || s_q.chan[c])
										s_d.shadow[c][ix] = nb;
								end
							end
						end
						s_d.addr = s_q.addr + 13'h0001;
						s_d.tx   = read_byte(s_q, s_q.addr + 13'h0001);
						if (s_q.left == LEN_LAST) begin
							s_d.phase   = ACP_DONE;
							s_d.sdio_oe = 1'b0;
						end else if (s_q.left != LEN_STREAM) begin
							s_d.left = s_q.left - 2'h1;
						end
					end
				end
				ACP_DONE: begin
					s_d.phase = ACP_DONE;
				end
				default: begin
					s_d.phase = ACP_IDLE;
				end
			endcase
		end else if (pins.sclk_fall && s_q.phase == ACP_DATA && s_q.rd) begin
			// Drive the next readback bit on the falling edge
			s_d.sdio_oe = 1'b1;
			s_d.sdio_o  = s_q.lsb_first ? s_q.tx[0] : s_q.tx[7];
			s_d.tx      = s_q.lsb_first ? {1'b0, s_q.tx[7:1]} : {s_q.tx[6:0], 1'b0};
		end
		// Converter controls from straps or from the live register bank
		if (s_q.decided && s_q.strap) begin
			s_d.fmt = {2{pins.sclk}};
			s_d.duty_cycle_stabilizer = pins.sdio;
			s_d.hiz = {2{pins.oe_n}};
			s_d.pd  = pins.power_down_pin;
			s_d.sb  = 1'b0;
		end else if (s_q.decided) begin
			for (int c = 0; c < 2; c++) begin
				s_d.fmt[c] = s_q.active[c][shadow_idx(ADDR_OUT_MODE)][FORMAT_BIT];
				s_d.hiz[c] = pins.oe_n | s_q.active[c][shadow_idx(ADDR_OUT_MODE)][OUT_DISABLE_BIT];
				s_d.inv[c] = s_q.active[c][shadow_idx(ADDR_OUT_PHASE)][DCO_INVERT_BIT];
			end
			s_d.duty_cycle_stabilizer = s_q.active[0][shadow_idx(ADDR_CLOCK)][DCS_BIT];
			s_d.pd  = pins.power_down_pin || s_q.active[0][shadow_idx(ADDR_POWER_MODE)][1:0] == PM_DOWN;
			s_d.sb  = s_q.active[0][shadow_idx(ADDR_POWER_MODE)][1:0] == PM_STANDBY;
		end
	end

	// State register
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			s_q           <= '0;
			s_q.phase     <= ACP_IDLE;
			s_q.chan      <= CHAN_IDX_RST;
			s_q.shadow    <= bank_rst;
			s_q.active    <= bank_rst;
			s_q.duty_cycle_stabilizer       <= CLOCK_RST[DCS_BIT];
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from state flops
	assign O_SERIAL_DATA_STABILIZER_STRAP    = s_q.sdio_o;
	assign O_SERIAL_DATA_STABILIZER_STRAP_OE = s_q.sdio_oe;
	assign O_STRAP_MODE                      = s_q.strap;
	assign O_POWER_DOWN                      = s_q.pd;
	assign O_STANDBY                         = s_q.sb;
	assign O_DUTY_CYCLE_STABILIZER           = s_q.duty_cycle_stabilizer;
	assign O_DATA_FORMAT_SELECT              = s_q.fmt;
	assign O_OUTPUT_HIZ                      = s_q.hiz;
	assign O_DATA_CLOCK_OUT_INVERT           = s_q.inv;
	assign O_DATA_CLOCK_OUT_DELAY            = {s_q.active[1][shadow_idx(ADDR_OUT_DELAY)],
		s_q.active[0][shadow_idx(ADDR_OUT_DELAY)]};
	assign O_TEST_MODE                       = {s_q.active[1][shadow_idx(ADDR_TEST_IO)],
		s_q.active[0][shadow_idx(ADDR_TEST_IO)]};
	assign O_OFFSET_ADJUST                   = {s_q.active[1][shadow_idx(ADDR_OFFSET)],
		s_q.active[0][shadow_idx(ADDR_OFFSET)]};
	assign O_VREF_SELECT                     = s_q.active[0][shadow_idx(ADDR_VREF)];

	// Checks on the port engine
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);

	chk_strap_float: assert property (s_q.strap |-> !s_q.sdio_oe)
		else $error("data pin driven in strap mode");
	chk_drive_read_only: assert property (s_q.sdio_oe |-> (s_q.phase == ACP_DATA && s_q.rd && !s_q.strap))
		else $error("data pin driven outside readback");
	chk_instr_sixteen: assert property ($rose(s_q.phase == ACP_DATA) |-> $past(s_q.icnt) == INSTR_LAST)
		else $error("data phase entered before sixteen instruction bits");
	chk_rw_flag: assert property ($rose(s_q.phase == ACP_DATA) |-> s_q.rd == $past(s_q.instr[INSTR_RW_POS-1]))
		else $error("read flag not taken from first instruction bit");
	chk_byte_whole: assert property ((s_q.phase == ACP_DATA && $past(s_q.phase) == ACP_DATA
			&& $changed(s_q.addr)) |-> $past(s_q.bcnt) == BIT_LAST)
		else $error("address advanced inside a byte");
	chk_last_byte: assert property ((s_q.phase == ACP_DATA && pins.sclk_rise && !pins.sel_n && s_q.bcnt == BIT_LAST
			&& s_q.left == LEN_LAST) |=> s_q.phase == ACP_DONE)
		else $error("frame not closed after counted bytes");
	chk_pause_keeps: assert property ((pins.sel_n && s_q.phase == ACP_DATA && s_q.bcnt == 3'h0
			&& s_q.left != LEN_STREAM) |=> s_q.phase == ACP_DATA && $stable(s_q.addr))
		else $error("paused frame lost its position");
	chk_msb_default: assert property ($past(I_RST) |-> !s_q.lsb_first)
		else $error("bit order not MSB first after reset");
	chk_xfer_apply: assert property (s_q.xfer |=> !s_q.xfer && s_q.active == $past(s_q.shadow))
		else $error("transfer did not update and clear");
	chk_stream_hold: assert property ((s_q.phase == ACP_DATA && s_q.left == LEN_STREAM && !pins.sel_n)
			|=> s_q.phase == ACP_DATA)
		else $error("streaming frame ended while select low");
endmodule // acp_config_port

/* include/acp_pkg.sv */
// Shared constants, encodings and reset values of the serial configuration port
package acp_pkg;
	// Frame geometry
	localparam logic [3:0]  INSTR_LAST      = 4'hF;
	localparam logic [3:0]  INSTR_BYTE_MASK = 4'h7;
	localparam logic [2:0]  BIT_LAST        = 3'h7;
	localparam int unsigned INSTR_RW_POS    = 15;
	localparam int unsigned INSTR_LEN_HI    = 14;
	localparam int unsigned INSTR_LEN_LO    = 13;
	localparam int unsigned ADDR_W          = 13;
	localparam logic [1:0]  LEN_STREAM      = 2'h3;
	localparam logic [1:0]  LEN_LAST        = 2'h0;

	// Register addresses
	localparam logic [12:0] ADDR_PORT_CFG   = 13'h0000;
	localparam logic [12:0] ADDR_CHIP_ID    = 13'h0001;
	localparam logic [12:0] ADDR_CHIP_GRADE = 13'h0002;
	localparam logic [12:0] ADDR_CHAN_IDX   = 13'h0005;
	localparam logic [12:0] ADDR_POWER_MODE = 13'h0008;
	localparam logic [12:0] ADDR_CLOCK      = 13'h0009;
	localparam logic [12:0] ADDR_TEST_IO    = 13'h000D;
	localparam logic [12:0] ADDR_OFFSET     = 13'h0010;
	localparam logic [12:0] ADDR_OUT_MODE   = 13'h0014;
	localparam logic [12:0] ADDR_OUT_PHASE  = 13'h0016;
	localparam logic [12:0] ADDR_OUT_DELAY  = 13'h0017;
	localparam logic [12:0] ADDR_VREF       = 13'h0018;
	localparam logic [12:0] ADDR_TRANSFER   = 13'h00FF;
	localparam logic [12:0] ADDR_SHADOW_LO  = ADDR_POWER_MODE;
	localparam logic [12:0] ADDR_SHADOW_HI  = ADDR_VREF;
	localparam int unsigned SHADOW_N        = 17;

	// Field positions
	localparam int unsigned LSB_FIRST_BIT   = 6;
	localparam int unsigned TRANSFER_BIT    = 0;
	localparam int unsigned DCS_BIT         = 0;
	localparam int unsigned FORMAT_BIT      = 0;
	localparam int unsigned OUT_DISABLE_BIT = 4;
	localparam int unsigned DCO_INVERT_BIT  = 7;
	localparam logic [1:0]  PM_DOWN         = 2'h1;
	localparam logic [1:0]  PM_STANDBY      = 2'h2;

	// Reset values
	localparam logic [1:0]  CHAN_IDX_RST    = 2'h3;
	localparam logic [7:0]  CLOCK_RST       = 8'h01;
	localparam logic [7:0]  VREF_RST        = 8'hC0;
	localparam logic [7:0]  ZERO_BYTE       = 8'h00;

	// Pin synchroniser lanes and their reset levels
	localparam int unsigned PIN_N           = 5;
	localparam int unsigned PIN_SCLK        = 0;
	localparam int unsigned PIN_SEL_N       = 1;
	localparam int unsigned PIN_SDIO        = 2;
	localparam int unsigned PIN_OE_N        = 3;
	localparam int unsigned PIN_POWER_DOWN_PIN        = 4;
	localparam logic [4:0]  SYNC_RST        = 5'h02;

	// Settling cycles before the strap decision is taken
	localparam logic [1:0]  STRAP_WAIT      = 2'h3;

	// Frame phases
	typedef enum logic [3:0] {
		ACP_IDLE  = 4'h1,
		ACP_INSTR = 4'h2,
		ACP_DATA  = 4'h4,
		ACP_DONE  = 4'h8
	} acp_phase_type;

	// Reset value of one shadowed setup register
	function automatic logic [7:0] acp_shadow_rst(input logic [4:0] idx);
		logic [12:0] a;
		a = ADDR_SHADOW_LO + {8'h00, idx};
		if (a == ADDR_CLOCK)
			return CLOCK_RST;
		else if (a == ADDR_VREF)
			return VREF_RST;
		return ZERO_BYTE;
	endfunction
endpackage

/* include/acp_pins_if.sv */
// Synchronised pin levels and edges passed from the pin stage to the port engine
`timescale 1ns/1ps
interface acp_pins_if;
	logic sclk;
	logic sel_n;
	logic sdio;
	logic oe_n;
	logic power_down_pin;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_rise;

	modport src (output sclk, sel_n, sdio, oe_n, power_down_pin, sclk_rise, sclk_fall, sel_rise);
	modport snk (input sclk, sel_n, sdio, oe_n, power_down_pin, sclk_rise, sclk_fall, sel_rise);
endinterface

/* hw/acp_pin_sync.sv */
// Two-stage synchronisers and edge finders for the asynchronous port pins
`timescale 1ns/1ps
module acp_pin_sync
	import acp_pkg::*;
(
	// Clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_rst,
	// Raw pins
	input  wire logic [acp_pkg::PIN_N-1:0] i_pins,
	// Synchronised view
	acp_pins_if.src                      pins
);
	import acp_pkg::*;

	typedef struct packed {
		logic [PIN_N-1:0] s1;
		logic [PIN_N-1:0] s2;
		logic             sclk3;
		logic             sel3;
	} acp_sync_type;

	acp_sync_type s_q;
	acp_sync_type s_d;

	// First stage feeds only the second; edges look at stages two and three
	always_comb begin
		s_d       = s_q;
		s_d.s1    = i_pins;
		s_d.s2    = s_q.s1;
		s_d.sclk3 = s_q.s2[PIN_SCLK];
		s_d.sel3  = s_q.s2[PIN_SEL_N];
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_q <= '{s1: SYNC_RST, s2: SYNC_RST, sclk3: 1'b0, sel3: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	// Levels and one-cycle edge pulses
	assign pins.sclk      = s_q.s2[PIN_SCLK];
	assign pins.sel_n     = s_q.s2[PIN_SEL_N];
	assign pins.sdio      = s_q.s2[PIN_SDIO];
	assign pins.oe_n      = s_q.s2[PIN_OE_N];
	assign pins.power_down_pin      = s_q.s2[PIN_POWER_DOWN_PIN];
	assign pins.sclk_rise = s_q.s2[PIN_SCLK] & ~s_q.sclk3;
	assign pins.sclk_fall = ~s_q.s2[PIN_SCLK] & s_q.sclk3;
	assign pins.sel_rise  = s_q.s2[PIN_SEL_N] & ~s_q.sel3;
endmodule // acp_pin_sync

/* tb/acp_host_model.sv */
// Serial host model that drives clock, select and the shared data line
`timescale 1ns/1ps
module acp_host_model (
	// Device side of the data line
	input  wire logic i_dev_d,
	input  wire logic i_dev_oe,
	// Host pins
	output logic      o_sclk,
	output logic      o_sel_n,
	output logic      o_line
);
	logic drv_q  = 1'b0;
	logic bit_q  = 1'b0;
	logic junk_q = 1'b0;
	int   clash  = 0;

	// Serial clock stands still and low between frames
	initial begin
		o_sclk = 1'b0;
		o_sel_n = 1'b0;
	end

	// A released line shows a changing pattern, never a held value
	always #40 junk_q = ~junk_q;
	assign o_line = i_dev_oe ? i_dev_d : (drv_q ? bit_q : junk_q);

	// Count every moment where both ends drive the line
	always @(i_dev_oe or drv_q) begin
		if (i_dev_oe && drv_q) clash++;
	end

	// Select level held outside frames
	task automatic set_sel(input logic v);
		o_sel_n = v;
	endtask

	// Static levels on the clock and data pins
	task automatic strap(input logic c, input logic d);
		o_sclk = c;
		bit_q = d;
		drv_q = 1'b1;
	endtask

	// Shift n bits; data changes while the clock is low, read at the rise
	task automatic shift(input logic [15:0] v, input int n, input bit lsb, input bit drive, output logic [15:0] r);
		int k;
		r = 16'h0000;
		for (int j = 0; j < n; j++) begin
			k = lsb ? j : n - 1 - j;
			drv_q = drive;
			bit_q = v[k];
			#200 o_sclk = 1'b1;
			r[k] = o_line;
			#120 o_sclk = 1'b0;
		end
	endtask

	// One frame: instruction then n bytes, optional pause between bytes
	task automatic frame(input bit rd, input logic [1:0] len, input logic [12:0] a, input int n, input bit lsb,
			input bit pause, inout logic [31:0] d);
		logic [15:0] r;
		o_sel_n = 1'b0;
		#160;
		shift({rd, len, a}, 16, 1'b0, 1'b1, r);
		for (int i = 0; i < n; i++) begin
			if (pause && i > 0) begin
				#160 o_sel_n = 1'b1;
				#320 o_sel_n = 1'b0;
				#160;
			end
			shift({8'h00, d[8*i+:8]}, 8, lsb, !rd, r);
			if (rd) d[8*i+:8] = r[7:0];
		end
		#160 o_sel_n = 1'b1;
		drv_q = 1'b0;
		#320;
	endtask
endmodule // acp_host_model

/* tb/test_adc_serial_config_port.sv */
// Self-checking bench of the serial configuration port against a register model
`timescale 1ns/1ps
module test_adc_serial_config_port;
	import acp_pkg::*;
	localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary identification value
	logic        clk   = 1'b0;
	logic        rst   = 1'b1;
	logic        oe_n  = 1'b0;
	logic        pd    = 1'b0;
	wire logic   sclk, sel_n, line, dev_d, dev_oe;
	logic        strap_m, pdn, sby, duty_cycle_stabilizer;
	logic [1:0]  fmt, hiz, inv;
	logic [15:0] dly, tst, off;
	logic [7:0]  vref;
	int          errors     = 0;
	int          num_checks = 0;
	logic [31:0] seed       = 32'd32742;
	logic [31:0] r;
	logic [7:0]  ma [256], mb [256], la [256], lb [256];
	logic [1:0]  chan;
	bit          lsb;

	// Core clock
	always #20 clk = ~clk;

	// Device under test and serial host
	acp_config_port #(.CHIP_ID(ID_VAL)) dut_u (.I_CORE_CLK(clk), .I_RST(rst),
		.I_SERIAL_CLOCK_FORMAT_STRAP(sclk), .I_SELECT_N(sel_n), .I_SERIAL_DATA_STABILIZER_STRAP(line),
		.O_SERIAL_DATA_STABILIZER_STRAP(dev_d), .O_SERIAL_DATA_STABILIZER_STRAP_OE(dev_oe),
		.I_OUTPUT_ENABLE_N(oe_n), .I_POWER_DOWN_PIN(pd), .O_STRAP_MODE(strap_m), .O_POWER_DOWN(pdn),
		.O_STANDBY(sby), .O_DUTY_CYCLE_STABILIZER(duty_cycle_stabilizer), .O_DATA_FORMAT_SELECT(fmt), .O_OUTPUT_HIZ(hiz),
		.O_DATA_CLOCK_OUT_INVERT(inv), .O_DATA_CLOCK_OUT_DELAY(dly), .O_TEST_MODE(tst),
		.O_OFFSET_ADJUST(off), .O_VREF_SELECT(vref));
	acp_host_model host_u (.i_dev_d(dev_d), .i_dev_oe(dev_oe), .o_sclk(sclk), .o_sel_n(sel_n), .o_line(line));

	// Fixed-seed xorshift source
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Register model: shadow and live banks per channel
	function automatic bit loc(input logic [12:0] a);
		return a inside {ADDR_TEST_IO, ADDR_OFFSET, ADDR_OUT_MODE, ADDR_OUT_PHASE, ADDR_OUT_DELAY};
	endfunction

	task automatic model_init();
		foreach (ma[i]) begin
			ma[i] = 8'h00;
			mb[i] = 8'h00;
		end
		ma[9] = CLOCK_RST;
		mb[9] = CLOCK_RST;
		ma[24] = VREF_RST;
		mb[24] = VREF_RST;
		la = ma;
		lb = mb;
		chan = CHAN_IDX_RST;
		lsb = 1'b0;
	endtask

	task automatic model_write(input logic [12:0] a, input logic [7:0] v);
		if (a == ADDR_CHAN_IDX) chan = v[1:0];
		if (a == ADDR_TRANSFER) begin
			if (v[TRANSFER_BIT]) begin
				la = ma;
				lb = mb;
			end
		end else begin
			if (!loc(a) || chan[0]) ma[a[7:0]] = v;
			if (!loc(a) || chan[1]) mb[a[7:0]] = v;
		end
		lsb = ma[0][LSB_FIRST_BIT];
	endtask

	function automatic logic [7:0] model_read(input logic [12:0] a);
		if (a == ADDR_CHIP_ID) return ID_VAL;
		if (a == ADDR_TRANSFER) return 8'h00;
		return (loc(a) && !chan[0]) ? mb[a[7:0]] : ma[a[7:0]];
	endfunction

	// Randomise the static pins, let them settle, compare every output except the readback data bit dev_d
	task automatic check_outs();
		r = xs();
		@(posedge clk);
		#1 oe_n = r[0];
		pd = r[1];
		repeat (8) @(posedge clk);
		#1;
		check("strap", 16'(strap_m), 16'h0000);
		check("dout_oe", 16'(dev_oe), 16'h0000);
		check("format", 16'(fmt), 16'({lb[20][0], la[20][0]}));
		check("hiz", 16'(hiz), 16'({lb[20][4] | oe_n, la[20][4] | oe_n}));
		check("invert", 16'(inv), 16'({lb[22][7], la[22][7]}));
		check("delay", dly, {lb[23], la[23]});
		check("test", tst, {lb[13], la[13]});
		check("offset", off, {lb[16], la[16]});
		check("vref", 16'(vref), 16'(la[24]));
		check("dcs", 16'(duty_cycle_stabilizer), 16'(la[9][0]));
		check("pdown", 16'(pdn), 16'(pd | (la[8][1:0] == PM_DOWN)));
		check("standby", 16'(sby), 16'(la[8][1:0] == PM_STANDBY));
	endtask

	task automatic wr(input logic [12:0] a, input logic [1:0] len, input int n, input bit p, input logic [31:0] d);
		host_u.frame(1'b0, len, a, n, lsb, p, d);
		for (int i = 0; i < n; i++) model_write(a + 13'(i), d[8*i+:8]);
		check_outs();
	endtask

	task automatic rd(input logic [12:0] a, input logic [1:0] len, input int n);
		logic [31:0] d;
		d = 32'h0;
		host_u.frame(1'b1, len, a, n, lsb, 1'b0, d);
		for (int i = 0; i < n; i++) check("readback", 16'(d[8*i+:8]), 16'(model_read(a + 13'(i))));
	endtask

	task automatic xfer();
		wr(ADDR_TRANSFER, LEN_LAST, 1, 1'b0, 32'h1);
	endtask

	task automatic do_reset(input logic s);
		host_u.set_sel(s);
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		repeat (10) @(posedge clk);
		model_init();
	endtask

	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		errors++;
		close_out();
	end

	// Main sequence
	initial begin
		do_reset(1'b0);
		host_u.set_sel(1'b1);
		check_outs();
		wr(ADDR_OUT_MODE, LEN_LAST, 1, 1'b0, 32'h11);
		xfer();
		rd(ADDR_TRANSFER, LEN_LAST, 1);
		wr(ADDR_OUT_PHASE, 2'h2, 3, 1'b1, xs());
		xfer();
		rd(ADDR_OUT_PHASE, 2'h2, 3);
		wr(ADDR_CHAN_IDX, LEN_LAST, 1, 1'b0, 32'h2);
		wr(ADDR_OFFSET, LEN_LAST, 1, 1'b0, xs());
		wr(ADDR_CHAN_IDX, LEN_LAST, 1, 1'b0, 32'h1);
		wr(ADDR_OFFSET, LEN_LAST, 1, 1'b0, xs());
		wr(ADDR_CHAN_IDX, LEN_LAST, 1, 1'b0, 32'h3);
		wr(ADDR_TEST_IO, LEN_LAST, 1, 1'b0, xs());
		xfer();
		rd(ADDR_OFFSET, LEN_LAST, 1);
		wr(ADDR_CHAN_IDX, LEN_LAST, 1, 1'b0, 32'h2);
		rd(ADDR_OFFSET, 2'h1, 2);
		for (int m = 0; m < 3; m++) begin
			r = xs();
			wr(ADDR_POWER_MODE, LEN_STREAM, 2, 1'b0, {23'h0, r[0], 6'h0, 2'(m == 2 ? 0 : m + 1)});
			xfer();
		end
		rd(ADDR_CHIP_ID, 2'h2, 3);
		wr(ADDR_PORT_CFG, LEN_LAST, 1, 1'b0, 32'h40);
		wr(ADDR_OUT_DELAY, LEN_LAST, 1, 1'b0, xs());
		xfer();
		rd(ADDR_OUT_DELAY, LEN_LAST, 1);
		check("clash", 16'(host_u.clash), 16'h0000);
		do_reset(1'b1);
		for (int k = 0; k < 6; k++) begin
			r = xs();
			host_u.strap(r[0], r[1]);
			@(posedge clk);
			#1 oe_n = r[2];
			pd = r[3];
			repeat (8) @(posedge clk);
			#1;
			check("strap", 16'(strap_m), 16'h0001);
			check("dout_oe", 16'(dev_oe), 16'h0000);
			check("format", 16'(fmt), 16'({2{r[0]}}));
			check("dcs", 16'(duty_cycle_stabilizer), 16'(r[1]));
			check("hiz", 16'(hiz), 16'({2{r[2]}}));
			check("pdown", 16'(pdn), 16'(r[3]));
		end
		close_out();
	end
endmodule // test_adc_serial_config_port
